// ==== sarh_defines.svh ====
// timing constants and cycle counts for the converter read controller
// Functional notes
// - abort by second convert edge 70 to 500 ns after start
// - read new result only after conversion end plus 20 ns
// - byte select transitions spaced at least 50 ns apart
// - at least 50 ns between chip select rise and busy fall
`ifndef SARH_DEFINES_SVH
`define SARH_DEFINES_SVH

`define SARH_CLK_NS       50
`define SARH_T_ACQ_NS     150
`define SARH_T_ABT_MIN_NS 70
`define SARH_T_ABT_MAX_NS 500
`define SARH_T_BUSY_MAX_NS 610
`define SARH_T_MSB_NS     20
`define SARH_T_BYTE_NS    50
`define SARH_T_BUSY_UP_NS 50
`define SARH_T_HOLD_NS    50
`define SARH_T_CSBUSY_NS  50

`define SARH_UP(t) (((t) + `SARH_CLK_NS - 1) / `SARH_CLK_NS)
`define SARH_DN(t) ((t) / `SARH_CLK_NS)

`define SARH_ACQ_CYC     `SARH_UP(`SARH_T_ACQ_NS)
`define SARH_ABT_MIN_CYC `SARH_UP(`SARH_T_ABT_MIN_NS)
`define SARH_ABT_MAX_CYC `SARH_DN(`SARH_T_ABT_MAX_NS)
`define SARH_BUSY_MAX_CYC `SARH_DN(`SARH_T_BUSY_MAX_NS)
`define SARH_MSB_CYC     `SARH_UP(`SARH_T_MSB_NS)
`define SARH_BYTE_CYC    `SARH_UP(`SARH_T_BYTE_NS)
`define SARH_BUSY_UP_CYC `SARH_UP(`SARH_T_BUSY_UP_NS)
`define SARH_HOLD_CYC    `SARH_UP(`SARH_T_HOLD_NS)

`define SARH_CNT_W   5
`define SARH_CNT_MAX 5'h1f
`define SARH_WORD_W  16
`define SARH_HI_MSB  15
`define SARH_HI_LSB  8
`define SARH_LO_MSB  7

`endif

// ==== sarh_pkg.sv ====
// types for the converter read controller
package sarh_pkg;
  typedef enum logic [2:0] {
    S_IDLE   = 3'h0,
    S_ACQ    = 3'h1,
    S_START  = 3'h3,
    S_WAIT   = 3'h2,
    S_SETTLE = 3'h6,
    S_READ   = 3'h7,
    S_PUSH   = 3'h5,
    S_GAP    = 3'h4
  } sarh_state_t;
endpackage

// ==== sarh_buf2.sv ====
// two-entry result buffer with valid/ready on both sides
`timescale 1ns/1ps
`default_nettype none
module sarh_buf2 #(
  parameter int W = 16
) (
  input  wire logic         clk,
  input  wire logic         rst_n,
  input  wire logic         in_valid,
  output logic              in_ready,
  input  wire logic [W-1:0] in_data,
  output logic              out_valid,
  input  wire logic         out_ready,
  output logic [W-1:0]      out_data
);
  logic [W-1:0] mem_r [2];
  logic         wr_idx_r;
  logic         rd_idx_r;
  logic [1:0]   count_r;
  logic         push;
  logic         pop;

  assign in_ready  = (count_r != 2'h2);
  assign out_valid = (count_r != 2'h0);
  assign out_data  = mem_r[rd_idx_r];
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      mem_r[0] <= '0;
      mem_r[1] <= '0;
    end else if (push) begin
      mem_r[wr_idx_r] <= in_data;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wr_idx_r <= 1'b0;
      rd_idx_r <= 1'b0;
      count_r  <= 2'h0;
    end else begin
      if (push) wr_idx_r <= !wr_idx_r;
      if (pop) rd_idx_r <= !rd_idx_r;
      if (push && !pop) count_r <= count_r + 2'h1;
      else if (pop && !push) count_r <= count_r - 2'h1;
    end
  end

  a_buf_no_over: assert property (@(posedge clk) disable iff (!rst_n)
    count_r != 2'h3)
    else $error("buffer count out of range");
  a_buf_out_hold: assert property (@(posedge clk) disable iff (!rst_n)
    out_valid && !out_ready |=> out_valid && $stable(out_data))
    else $error("buffered word changed while stalled");
endmodule
`default_nettype wire

// ==== sarh_ctrl.sv ====
// host controller: starts, optionally aborts and reads one conversion
`timescale 1ns/1ps
`default_nettype none
`include "sarh_defines.svh"
module sarh_ctrl (
  input  wire logic                     clk,
  input  wire logic                     rst_n,
  input  wire logic                     start_valid,
  output logic                          start_ready,
  input  wire logic                     byte_mode,
  input  wire logic                     abort_req,
  output logic                          aborted,
  output logic                          res_valid,
  input  wire logic                     res_ready,
  output logic [`SARH_WORD_W-1:0]       res_data,
  output logic                          convert_start_n,
  output logic                          cs_n,
  output logic                          rd_n,
  output logic                          byte_sel,
  input  wire logic                     busy,
  input  wire logic [`SARH_WORD_W-1:0]  bus_in
);
  sarh_pkg::sarh_state_t state_r;
  sarh_pkg::sarh_state_t state_nxt;
  logic [`SARH_CNT_W-1:0]  cnt_r;
  logic [`SARH_CNT_W-1:0]  since_r;
  logic [`SARH_WORD_W-1:0] word_r;
  logic                    byte_mode_r;
  logic                    phase_r;
  logic                    phase_set;
  logic                    busy_d_r;
  logic                    cstart_d_r;
  logic                    abort_fire;
  logic                    conv_done;
  logic                    busy_quiet;
  logic                    buf_ready;
  logic                    aborted_r;
  logic                    cstart_n_r;
  logic                    cs_n_r;
  logic                    rd_n_r;
  logic                    byte_sel_r;

  assign start_ready     = (state_r == sarh_pkg::S_IDLE);
  assign aborted         = aborted_r;
  assign convert_start_n = cstart_n_r;
  assign cs_n            = cs_n_r;
  assign rd_n            = rd_n_r;
  assign byte_sel        = byte_sel_r;

  // elapsed cycles counted from the start edge, as the edge will land
  assign abort_fire = (state_r == sarh_pkg::S_WAIT) && abort_req &&
    (since_r + 5'h01 >= 5'(`SARH_ABT_MIN_CYC)) &&
    (since_r + 5'h01 <= 5'(`SARH_ABT_MAX_CYC));
  // busy must have had time to rise before its low level means done
  assign conv_done = (!busy && cnt_r >= 5'(`SARH_BUSY_UP_CYC)) ||
    (cnt_r >= 5'(`SARH_BUSY_MAX_CYC));
  // busy sampled low on this cycle and the previous one covers the 50 ns spacing
  assign busy_quiet = !busy && !busy_d_r;
  assign phase_set  = (state_r == sarh_pkg::S_READ) && byte_mode_r &&
    !phase_r;

  always_comb begin
    state_nxt = state_r;
    unique case (state_r)
      sarh_pkg::S_IDLE: begin
        if (start_valid) state_nxt = sarh_pkg::S_ACQ;
      end
      sarh_pkg::S_ACQ: begin
        if (cnt_r >= 5'(`SARH_ACQ_CYC - 1)) state_nxt = sarh_pkg::S_START;
      end
      sarh_pkg::S_START: begin
        state_nxt = sarh_pkg::S_WAIT;
      end
      sarh_pkg::S_WAIT: begin
        if (abort_fire) state_nxt = sarh_pkg::S_GAP;
        else if (conv_done) state_nxt = sarh_pkg::S_SETTLE;
      end
      sarh_pkg::S_SETTLE: begin
        if (cnt_r >= 5'(`SARH_MSB_CYC - 1)) state_nxt = sarh_pkg::S_READ;
      end
      sarh_pkg::S_READ: begin
        if (!byte_mode_r ||
            (phase_r && cnt_r >= 5'(`SARH_BYTE_CYC))) begin
          state_nxt = sarh_pkg::S_PUSH;
        end
      end
      sarh_pkg::S_PUSH: begin
        if (buf_ready) state_nxt = sarh_pkg::S_GAP;
      end
      sarh_pkg::S_GAP: begin
        if (cnt_r >= 5'(`SARH_HOLD_CYC - 1) && busy_quiet) begin
          state_nxt = sarh_pkg::S_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_r <= sarh_pkg::S_IDLE;
    end else begin
      state_r <= state_nxt;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_r <= 5'h00;
    end else if (state_nxt != state_r || phase_set) begin
      cnt_r <= 5'h00;
    end else if (cnt_r != `SARH_CNT_MAX) begin
      cnt_r <= cnt_r + 5'h01;
    end
  end

  // cycles since the last falling edge of convert_start_n
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cstart_d_r <= 1'b1;
      since_r    <= `SARH_CNT_MAX;
      busy_d_r   <= 1'b0;
    end else begin
      cstart_d_r <= cstart_n_r;
      busy_d_r   <= busy;
      if (cstart_d_r && !cstart_n_r) since_r <= 5'h01;
      else if (since_r != `SARH_CNT_MAX) since_r <= since_r + 5'h01;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      byte_mode_r <= 1'b0;
      phase_r     <= 1'b0;
    end else begin
      if (state_r == sarh_pkg::S_IDLE && start_valid) begin
        byte_mode_r <= byte_mode;
      end
      if (state_r == sarh_pkg::S_IDLE) phase_r <= 1'b0;
      else if (phase_set) phase_r <= 1'b1;
    end
  end

  // sampled only inside the read window, never near a strobe edge
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      word_r <= '0;
    end else if (state_r == sarh_pkg::S_READ) begin
      if (!byte_mode_r) begin
        word_r <= bus_in;
      end else if (!phase_r) begin
        word_r[`SARH_HI_MSB:`SARH_HI_LSB] <=
          bus_in[`SARH_HI_MSB:`SARH_HI_LSB];
      end else if (cnt_r >= 5'(`SARH_BYTE_CYC)) begin
        word_r[`SARH_LO_MSB:0] <= bus_in[`SARH_HI_MSB:`SARH_HI_LSB];
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cstart_n_r <= 1'b1;
      aborted_r  <= 1'b0;
    end else begin
      cstart_n_r <= !(state_nxt == sarh_pkg::S_START || abort_fire);
      aborted_r  <= abort_fire;
    end
  end

  // chip select stays low through an abort pulse, rises only once busy
  // has settled low
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cs_n_r <= 1'b1;
    end else begin
      cs_n_r <= (state_nxt == sarh_pkg::S_IDLE) ||
        (state_nxt == sarh_pkg::S_GAP && state_r != sarh_pkg::S_WAIT &&
         busy_quiet);
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rd_n_r <= 1'b1;
    end else begin
      rd_n_r <= !(state_nxt == sarh_pkg::S_SETTLE ||
                  state_nxt == sarh_pkg::S_READ);
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      byte_sel_r <= 1'b0;
    end else if (phase_set) begin
      byte_sel_r <= 1'b1;
    end else if (state_nxt == sarh_pkg::S_GAP) begin
      byte_sel_r <= 1'b0;
    end
  end

  sarh_buf2 #(
    .W (`SARH_WORD_W)
  ) u_buf (
    .clk       (clk),
    .rst_n     (rst_n),
    .in_valid  (state_r == sarh_pkg::S_PUSH),
    .in_ready  (buf_ready),
    .in_data   (word_r),
    .out_valid (res_valid),
    .out_ready (res_ready),
    .out_data  (res_data)
  );

  a_acq_before_start: assert property (
    @(posedge clk) disable iff (!rst_n)
    $fell(convert_start_n) && state_r == sarh_pkg::S_START |->
    !cs_n && $past(cs_n, 3) == 1'b0)
    else $error("conversion started before acquisition elapsed");
  a_start_pulse_one: assert property (
    @(posedge clk) disable iff (!rst_n)
    $fell(convert_start_n) |=> convert_start_n)
    else $error("convert start low longer than one cycle");
  a_abort_window_ok: assert property (
    @(posedge clk) disable iff (!rst_n)
    $fell(convert_start_n) && state_r == sarh_pkg::S_GAP |->
    since_r >= 5'(`SARH_ABT_MIN_CYC) &&
    since_r <= 5'(`SARH_ABT_MAX_CYC) && !cs_n)
    else $error("abort edge outside 70..500 ns window");
  a_read_after_done: assert property (
    @(posedge clk) disable iff (!rst_n)
    $fell(rd_n) |->
    $past(busy) == 1'b0 || since_r >= 5'(`SARH_BUSY_MAX_CYC + 2))
    else $error("read strobe before conversion end");
  a_byte_sel_space: assert property (
    @(posedge clk) disable iff (!rst_n)
    $changed(byte_sel) |=> $stable(byte_sel))
    else $error("byte select toggled twice within 50 ns");
  a_cs_rise_quiet: assert property (
    @(posedge clk) disable iff (!rst_n)
    $rose(cs_n) |-> $past(busy) == 1'b0 && $past(busy, 2) == 1'b0)
    else $error("chip select rose too close to busy fall");
  a_rd_before_cs: assert property (
    @(posedge clk) disable iff (!rst_n)
    $rose(cs_n) |-> rd_n && $past(rd_n))
    else $error("chip select rose while read strobe low");
  a_wait_bounded: assert property (
    @(posedge clk) disable iff (!rst_n)
    state_r == sarh_pkg::S_WAIT |-> cnt_r <= 5'(`SARH_BUSY_MAX_CYC))
    else $error("busy wait ran past 610 ns");
  a_sample_window: assert property (
    @(posedge clk) disable iff (!rst_n)
    state_r == sarh_pkg::S_READ |-> !rd_n && !cs_n && $past(!rd_n))
    else $error("bus sampled outside read window");
  a_busy_wait_cs: assert property (
    @(posedge clk) disable iff (!rst_n)
    state_r == sarh_pkg::S_WAIT |-> !cs_n && rd_n)
    else $error("chip select not held during conversion");
endmodule
`default_nettype wire

// ==== sarh_buf2_unused_guard.sv ====
// intentionally empty
`timescale 1ns/1ps
`default_nettype none
`default_nettype wire

// ==== sarh_dev_model.sv ====
// behavioural model of the sampling converter seen from the host
`timescale 1ns/1ps
`default_nettype none
`include "sarh_defines.svh"
module sarh_dev_model (
  input  wire logic                    clk,
  input  wire logic                    rst_n,
  input  wire logic                    convert_start_n,
  input  wire logic                    cs_n,
  input  wire logic                    rd_n,
  input  wire logic                    byte_sel,
  input  wire logic [4:0]              conv_cyc,
  input  wire logic [`SARH_WORD_W-1:0] next_res,
  output logic                         busy,
  output logic [`SARH_WORD_W-1:0]      bus_in
);
  logic                    cst_q_r;
  logic                    cs_q_r;
  logic                    acq_r;
  logic [4:0]              cnt_r;
  logic [`SARH_WORD_W-1:0] hold_r;
  logic [`SARH_WORD_W-1:0] res_r;
  logic [`SARH_WORD_W-1:0] last_r;
  logic                    drv;
  logic [`SARH_WORD_W-1:0] val;
  logic                    fall;

  assign fall = cst_q_r && !convert_start_n && !cs_n;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cst_q_r <= 1'b1;
      cs_q_r  <= 1'b1;
      acq_r   <= 1'b0;
      busy    <= 1'b0;
      cnt_r   <= 5'h00;
      hold_r  <= 16'h0000;
      res_r   <= 16'h0000;
    end else begin
      cst_q_r <= convert_start_n;
      cs_q_r  <= cs_n;
      if (cs_q_r && !cs_n)
        acq_r <= 1'b1;
      if (fall && busy) begin
        busy  <= 1'b0;
        cnt_r <= 5'h00;
      end else if (fall) begin
        busy   <= 1'b1;
        cnt_r  <= conv_cyc;
        acq_r  <= 1'b0;
        // no acquisition means a corrupt sample
        hold_r <= acq_r ? next_res : ~next_res;
      end else if (busy && cnt_r <= 5'h01) begin
        busy  <= 1'b0;
        res_r <= hold_r;
      end else if (busy) begin
        cnt_r <= cnt_r - 5'h01;
      end
    end
  end

  assign drv = !cs_n && !rd_n;
  assign val = byte_sel ? {res_r[7:0], 8'hff} : res_r;
  // released bus shows the inverse so a late sample never matches
  assign bus_in = drv ? val : ~last_r;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n)
      last_r <= 16'h0000;
    else if (drv)
      last_r <= val;
  end
endmodule
`default_nettype wire

// ==== tb.sv ====
// self-checking testbench for the converter read controller
`timescale 1ns/1ps
`default_nettype none
`include "sarh_defines.svh"
`define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin n_errors++; \
  $display("unexpected at %0t: got %h want %h", $time, a, b); end end
module tb;
  logic                    clk;
  logic                    rst_n;
  logic                    start_valid;
  logic                    start_ready;
  logic                    byte_mode;
  logic                    abort_req;
  logic                    aborted;
  logic                    res_valid;
  logic                    res_ready;
  logic [`SARH_WORD_W-1:0] res_data;
  logic                    convert_start_n;
  logic                    cs_n;
  logic                    rd_n;
  logic                    byte_sel;
  logic                    busy;
  logic [`SARH_WORD_W-1:0] bus_in;
  logic [4:0]              conv_cyc;
  logic [`SARH_WORD_W-1:0] next_res;
  int                      n_errors;
  int                      n_checks;

  sarh_ctrl u_sarh_ctrl (.clk(clk), .rst_n(rst_n),
    .start_valid(start_valid), .start_ready(start_ready),
    .byte_mode(byte_mode), .abort_req(abort_req), .aborted(aborted),
    .res_valid(res_valid), .res_ready(res_ready), .res_data(res_data),
    .convert_start_n(convert_start_n), .cs_n(cs_n), .rd_n(rd_n),
    .byte_sel(byte_sel), .busy(busy), .bus_in(bus_in));

  sarh_dev_model u_sarh_dev_model (.clk(clk), .rst_n(rst_n),
    .convert_start_n(convert_start_n), .cs_n(cs_n), .rd_n(rd_n),
    .byte_sel(byte_sel), .conv_cyc(conv_cyc), .next_res(next_res),
    .busy(busy), .bus_in(bus_in));

  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  task automatic end_sim();
    $display("checks %0d errors %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #5;
  endtask

  task automatic kick(input logic bm, input logic [15:0] v,
                      input logic [4:0] c);
    while (start_ready !== 1'b1)
      tick(1);
    byte_mode = bm;
    next_res = v;
    conv_cyc = c;
    start_valid = 1'b1;
    tick(1);
    start_valid = 1'b0;
    `CHK(start_ready, 1'b0)
    `CHK(cs_n, 1'b0)
    tick(1);
  endtask

  task automatic get(output logic [15:0] d);
    int i;
    i = 0;
    while (res_valid !== 1'b1 && i < 80) begin
      tick(1);
      i++;
    end
    `CHK(res_valid, 1'b1)
    d = res_data;
    res_ready = 1'b1;
    tick(1);
    res_ready = 1'b0;
    tick(1);
  endtask

  task automatic t_word(input logic [15:0] v);
    logic [15:0] d;
    kick(1'b0, v, 5'h03);
    get(d);
    `CHK(d, v)
  endtask

  task automatic t_slow();
    logic [15:0] d;
    kick(1'b0, 16'h1234, 5'h0a);
    tick(8);
    `CHK(rd_n, 1'b1)
    get(d);
    `CHK(d, 16'h1234)
  endtask

  task automatic t_byte();
    logic [15:0] d;
    kick(1'b1, 16'h5aa5, 5'h04);
    get(d);
    `CHK(d, 16'h5aa5)
    `CHK(byte_sel, 1'b0)
  endtask

  task automatic t_fill();
    logic [15:0] d;
    kick(1'b0, 16'h0f0f, 5'h03);
    kick(1'b1, 16'hc3c3, 5'h05);
    kick(1'b0, 16'h8001, 5'h03);
    tick(30);
    `CHK(res_data, 16'h0f0f)
    get(d);
    `CHK(d, 16'h0f0f)
    get(d);
    `CHK(d, 16'hc3c3)
    get(d);
    `CHK(d, 16'h8001)
  endtask

  task automatic t_abort();
    int i;
    abort_req = 1'b1;
    kick(1'b0, 16'hdead, 5'h0a);
    i = 0;
    while (aborted !== 1'b1 && i < 20) begin
      tick(1);
      i++;
    end
    `CHK(aborted, 1'b1)
    `CHK(convert_start_n, 1'b0)
    `CHK(cs_n, 1'b0)
    abort_req = 1'b0;
    tick(20);
    `CHK(res_valid, 1'b0)
  endtask

  initial begin
    #(5000 * 50);
    n_errors++;
    end_sim();
  end

  initial begin
    n_errors = 0;
    n_checks = 0;
    rst_n = 1'b0;
    start_valid = 1'b0;
    byte_mode = 1'b0;
    abort_req = 1'b0;
    res_ready = 1'b0;
    conv_cyc = 5'h03;
    next_res = 16'h0000;
    tick(3);
    `CHK(convert_start_n, 1'b1)
    rst_n = 1'b1;
    t_word(16'hffff);
    t_slow();
    t_byte();
    t_fill();
    t_abort();
    t_word(16'h0000);
    end_sim();
  end
endmodule
`default_nettype wire
